// ===== include/pdto_pkg.sv
package pdto_pkg;
    // register offsets on the management bus
    localparam logic [7:0] CTRL_ADDR = 8'h90;
    localparam logic [7:0] OFF0_ADDR = 8'h94;
    localparam logic [7:0] OFF1_ADDR = 8'h95;
    // power-on values
    localparam logic [7:0] CTRL_RESET = 8'h00;
    localparam logic [7:0] OFF_RESET = 8'h00;
    // control fields
    localparam int IVL_LSB = 3;
    localparam int IVL_MSB = 5;
    localparam int CAPT_BIT = 6;
    localparam int DYN_BIT = 7;
    localparam logic [7:0] CTRL_WR_MASK = 8'hf8;
    // interval bases in monitoring cycles
    localparam logic [11:0] DEC_BASE = 12'h008;
    localparam logic [11:0] INC_BASE = 12'h010;
    // offset and temperature limits, signed bytes
    localparam logic signed [7:0] OFF_MIN = 8'shc1;
    localparam logic signed [7:0] TEMP_MAX = 8'sh7f;
    localparam logic signed [7:0] TEMP_MIN = 8'sh80;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [11:0] ZERO_CNT = 12'h000;
    localparam logic [7:0] ONE_BYTE = 8'h01;
endpackage

// ===== rtl/pdto_block.sv
`timescale 1ns/10ps
// Behaviour
// (RL1) Interval code in control bits 5:3 sets the wait between downward start-temperature steps: 8 monitoring cycles for code 0, doubling per code up to 1024.
// (RL2) Upward steps wait twice as long: 16 monitoring cycles for code 0, doubling up to 2048.
// (RL3) With capture enabled (bit 6), an overtemperature assertion copies the channel 0 reading into the operating point.
// (RL4) With capture disabled, overtemperature is ignored and the operating point keeps its programmed value.
// (RL5) With dynamic enable (bit 7) set, the start temperature is moved using current temperature, operating point and the zone limits.
// (RL6) With dynamic enable clear, the start temperature stays at its programmed value.
// (RL7) The channel 0 offset register is added to every channel 0 measurement.
// (RL8) The channel 1 offset register is added to every channel 1 measurement.
// (RL9) Each offset holds a correction from -63 to +127 degrees in 1 degree steps.
// (RL10) While the configuration lock is set the control register cannot be written.
// (RL11) While the configuration lock is set the offset registers cannot be written.
// (RL12) At reset the control and both offset registers hold zero.
// (RL13) Offsets are signed bytes added before any comparison, so negative offsets lower the reading.
module pdto_block (
    input wire logic clk,
    input wire logic srst,
    input wire logic [7:0] regAddr,
    input wire logic regWrEn,
    input wire logic [7:0] regWrData,
    output logic [7:0] regRdData,
    input wire logic configLock,
    input wire logic monitorTick,
    input wire logic overtempInput,
    input wire logic peciZeroValid,
    input wire logic signed [7:0] peciZeroRaw,
    input wire logic peciOneValid,
    input wire logic signed [7:0] peciOneRaw,
    input wire logic signed [7:0] tminProgrammed,
    input wire logic signed [7:0] opPointProgrammed,
    input wire logic signed [7:0] zoneLowLimit,
    input wire logic signed [7:0] zoneHighLimit,
    output logic signed [7:0] peciZeroTemp,
    output logic signed [7:0] peciOneTemp,
    output logic signed [7:0] opPoint,
    output logic opPointCaptured,
    output logic signed [7:0] tminActive,
    output logic dynamicActive
);
    import pdto_pkg::*;

    typedef struct packed {
        logic [7:0] ctrl;
        logic signed [7:0] off0;
        logic signed [7:0] off1;
        logic [7:0] rdData;
        logic signed [7:0] temp0;
        logic signed [7:0] temp1;
        logic signed [7:0] opPt;
        logic capt;
        logic [11:0] decCnt;
        logic [11:0] incCnt;
        logic signed [7:0] tmin;
    } pdto_state_type;

    pdto_state_type state_q;
    pdto_state_type state_d;

    // register read value by offset; unmapped offsets read zero
    function automatic logic [7:0] readReg(input logic [7:0] a,
                                           input pdto_state_type s);
        case (a)
            CTRL_ADDR: readReg = s.ctrl;
            OFF0_ADDR: readReg = s.off0;
            OFF1_ADDR: readReg = s.off1;
            default: readReg = ZERO_BYTE;
        endcase
    endfunction

    // signed add with saturation, keeps the reading from wrapping around
    function automatic logic signed [7:0] addSat(input logic signed [7:0] a,
                                                 input logic signed [7:0] b);
        logic signed [8:0] sum;
        sum = 9'(a) + 9'(b);
        if (sum > 9'(TEMP_MAX)) begin
            addSat = TEMP_MAX;
        end else if (sum < 9'(TEMP_MIN)) begin
            addSat = TEMP_MIN;
        end else begin
            addSat = sum[7:0];
        end
    endfunction

    // offsets below the lowest supported correction are pinned to it
    function automatic logic signed [7:0] clampOff(input logic [7:0] v);
        if ($signed(v) < OFF_MIN) begin
            clampOff = OFF_MIN;
        end else begin
            clampOff = $signed(v);
        end
    endfunction

    logic [2:0] ivlCode;
    logic [11:0] decWait;
    logic [11:0] incWait;
    logic dynEn;
    logic captEn;
    logic wrOk;

    // interval waits from the control code
    always_comb begin
        ivlCode = state_q.ctrl[IVL_MSB:IVL_LSB];
        decWait = DEC_BASE << ivlCode; // RL1
        incWait = INC_BASE << ivlCode; // RL2
        dynEn = state_q.ctrl[DYN_BIT];
        captEn = state_q.ctrl[CAPT_BIT];
        wrOk = regWrEn && !configLock; // RL10 RL11
    end

    // next state
    always_comb begin
        state_d = state_q;
        state_d.capt = 1'b0;
        // register writes; reserved low control bits stay zero
        if (wrOk && regAddr == CTRL_ADDR) begin
            state_d.ctrl = regWrData & CTRL_WR_MASK; // RL10
        end
        if (wrOk && regAddr == OFF0_ADDR) begin
            state_d.off0 = clampOff(regWrData); // RL9 RL11
        end
        if (wrOk && regAddr == OFF1_ADDR) begin
            state_d.off1 = clampOff(regWrData); // RL9 RL11
        end
        state_d.rdData = readReg(regAddr, state_q);
        // offset applied on each new measurement, before any comparison
        if (peciZeroValid) begin
            state_d.temp0 = addSat(peciZeroRaw, state_q.off0); // RL7 RL13
        end
        if (peciOneValid) begin
            state_d.temp1 = addSat(peciOneRaw, state_q.off1); // RL8 RL13
        end
        // operating point follows software while capture is disabled; with capture enabled it holds until a capture fires
        if (captEn && overtempInput) begin
            state_d.opPt = state_q.temp0; // RL3
            state_d.capt = 1'b1;
        end else if (!captEn) begin
            state_d.opPt = opPointProgrammed; // RL4
        end
        // start temperature loop, stepped on monitoring cycles only
        if (!dynEn) begin
            state_d.tmin = tminProgrammed; // RL6
            state_d.decCnt = ZERO_CNT;
            state_d.incCnt = ZERO_CNT;
        end else if (monitorTick) begin
            state_d.decCnt = state_q.decCnt + 12'h001;
            state_d.incCnt = state_q.incCnt + 12'h001;
            // hot zone pulls the start point down toward the low limit
            if (state_q.decCnt + 12'h001 >= decWait) begin // RL1
                state_d.decCnt = ZERO_CNT;
                if ((state_q.temp0 > state_q.opPt ||
                     state_q.temp0 > zoneHighLimit) &&
                    state_q.tmin > zoneLowLimit) begin
                    state_d.tmin = state_q.tmin - ONE_BYTE; // RL5
                end
            end
            // cool zone lets it drift back up; slower to avoid hunting
            if (state_q.incCnt + 12'h001 >= incWait) begin // RL2
                state_d.incCnt = ZERO_CNT;
                if (state_q.temp0 < zoneLowLimit &&
                    state_q.tmin < zoneHighLimit &&
                    state_q.tmin < state_q.opPt) begin
                    state_d.tmin = state_q.tmin + ONE_BYTE; // RL5
                end
            end
        end
        // a new interval code restarts both waits, so a count that the
        // old code ran up can never sit past a shorter new window
        if (wrOk && regAddr == CTRL_ADDR) begin
            state_d.decCnt = ZERO_CNT; // RL1
            state_d.incCnt = ZERO_CNT; // RL2
        end
    end

    // state register
    always_ff @(posedge clk) begin
        if (srst) begin
            state_q <= '0;
            state_q.ctrl <= CTRL_RESET; // RL12
            state_q.off0 <= OFF_RESET; // RL12
            state_q.off1 <= OFF_RESET; // RL12
        end else begin
            state_q <= state_d;
        end
    end

    // outputs straight from flip-flops
    assign regRdData = state_q.rdData;
    assign peciZeroTemp = state_q.temp0;
    assign peciOneTemp = state_q.temp1;
    assign opPoint = state_q.opPt;
    assign opPointCaptured = state_q.capt;
    assign tminActive = state_q.tmin;
    assign dynamicActive = dynEn;

    // checks
    ctrl_lock_a: assert property (@(posedge clk) disable iff (srst) // RL10
        configLock |=> state_q.ctrl == $past(state_q.ctrl))
        else $error("control changed under lock");
    off_lock_a: assert property (@(posedge clk) disable iff (srst) // RL11
        configLock |=> state_q.off0 == $past(state_q.off0) &&
                       state_q.off1 == $past(state_q.off1))
        else $error("offset changed under lock");
    reset_zero_a: assert property (@(posedge clk) // RL12
        srst |=> state_q.ctrl == ZERO_BYTE && state_q.off0 == ZERO_BYTE &&
                 state_q.off1 == ZERO_BYTE)
        else $error("registers not zero after reset");
    off_range_a: assert property (@(posedge clk) disable iff (srst) // RL9
        state_q.off0 >= OFF_MIN && state_q.off1 >= OFF_MIN)
        else $error("offset below range");
    add_zero_a: assert property (@(posedge clk) disable iff (srst) // RL7
        peciZeroValid |=> peciZeroTemp ==
            addSat($past(peciZeroRaw), $past(state_q.off0)))
        else $error("channel 0 offset not applied");
    add_one_a: assert property (@(posedge clk) disable iff (srst) // RL8
        peciOneValid |=> peciOneTemp ==
            addSat($past(peciOneRaw), $past(state_q.off1)))
        else $error("channel 1 offset not applied");
    capt_take_a: assert property (@(posedge clk) disable iff (srst) // RL3
        captEn && overtempInput |=> opPointCaptured &&
            opPoint == $past(peciZeroTemp))
        else $error("capture missed");
    capt_ignore_a: assert property (@(posedge clk) disable iff (srst) // RL4
        !captEn |=> !opPointCaptured &&
            opPoint == $past(opPointProgrammed))
        else $error("capture while disabled");
    tmin_hold_a: assert property (@(posedge clk) disable iff (srst) // RL6
        !dynEn |=> tminActive == $past(tminProgrammed))
        else $error("start temperature moved while disabled");
    dec_bound_a: assert property (@(posedge clk) disable iff (srst) // RL1
        state_q.decCnt < decWait)
        else $error("decrease wait overrun");
    inc_bound_a: assert property (@(posedge clk) disable iff (srst) // RL2
        state_q.incCnt < incWait)
        else $error("increase wait overrun");
    tmin_step_a: assert property (@(posedge clk) disable iff (srst) // RL5
        dynEn && !monitorTick |=> tminActive == $past(tminActive))
        else $error("start temperature moved off a tick");

    // register writes land with the mask and clamp applied
    ctrl_write_a: assert property (@(posedge clk) disable iff (srst) // RL10
        wrOk && regAddr == CTRL_ADDR |=>
            state_q.ctrl == ($past(regWrData) & CTRL_WR_MASK))
        else $error("control write lost");
    off0_write_a: assert property (@(posedge clk) disable iff (srst) // RL11
        wrOk && regAddr == OFF0_ADDR |=>
            state_q.off0 == clampOff($past(regWrData)))
        else $error("channel 0 offset write lost");
    off1_write_a: assert property (@(posedge clk) disable iff (srst) // RL11
        wrOk && regAddr == OFF1_ADDR |=>
            state_q.off1 == clampOff($past(regWrData)))
        else $error("channel 1 offset write lost");
    rsvd_zero_a: assert property (@(posedge clk) disable iff (srst) // RL1
        (state_q.ctrl & ~CTRL_WR_MASK) == ZERO_BYTE)
        else $error("reserved control bits set");
    rd_data_a: assert property (@(posedge clk) disable iff (srst) // RL12
        regRdData == readReg($past(regAddr), $past(state_q)))
        else $error("read data wrong");

    // capture pulse only from an enabled overtemperature
    capt_hold_a: assert property (@(posedge clk) disable iff (srst) // RL3
        captEn && !overtempInput |=> !opPointCaptured &&
            opPoint == $past(opPoint))
        else $error("operating point moved without capture");
    capt_pulse_a: assert property (@(posedge clk) disable iff (srst) // RL3
        opPointCaptured |-> $past(captEn && overtempInput))
        else $error("spurious capture pulse");
    rst_outs_a: assert property (@(posedge clk) // RL12
        srst |=> tminActive == ZERO_BYTE && opPoint == ZERO_BYTE &&
            !opPointCaptured)
        else $error("outputs not zero after reset");

    // corrected readings hold between measurements
    temp0_hold_a: assert property (@(posedge clk) disable iff (srst) // RL7
        !peciZeroValid |=> peciZeroTemp == $past(peciZeroTemp))
        else $error("channel 0 reading changed without sample");
    temp1_hold_a: assert property (@(posedge clk) disable iff (srst) // RL8
        !peciOneValid |=> peciOneTemp == $past(peciOneTemp))
        else $error("channel 1 reading changed without sample");

    // loop steps by one degree at window ends only
    tmin_delta_a: assert property (@(posedge clk) disable iff (srst) // RL5
        dynEn |=> tminActive == $past(tminActive) ||
            tminActive == $past(tminActive) + ONE_BYTE ||
            tminActive == $past(tminActive) - ONE_BYTE)
        else $error("start temperature jumped");
    dec_fire_a: assert property (@(posedge clk) disable iff (srst) // RL1
        dynEn && monitorTick && state_q.decCnt + 12'h001 >= decWait |=>
            state_q.decCnt == ZERO_CNT)
        else $error("decrease window not restarted");
    inc_fire_a: assert property (@(posedge clk) disable iff (srst) // RL2
        dynEn && monitorTick && state_q.incCnt + 12'h001 >= incWait |=>
            state_q.incCnt == ZERO_CNT)
        else $error("increase window not restarted");
    cnt_clear_a: assert property (@(posedge clk) disable iff (srst) // RL6
        !dynEn |=> state_q.decCnt == ZERO_CNT && state_q.incCnt == ZERO_CNT)
        else $error("wait counters run while disabled");
endmodule

// ===== verif/pdto_block_bench.sv
`timescale 1ns/10ps
`define CMP(g, e) begin testsRun++; if ((g) !== (e)) begin miscompares++; \
    $display("BAD %0t got %h want %h", $time, g, e); end end
module pdto_block_bench;
    import pdto_pkg::*;
    logic clk = 0, srst = 1, regWrEn = 0, configLock = 0, monitorTick = 0;
    logic overtempInput = 0, peciZeroValid = 0, peciOneValid = 0;
    logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData;
    logic signed [7:0] peciZeroRaw = 8'h00, peciOneRaw = 8'h00;
    logic signed [7:0] tminProgrammed = 8'h30, opPointProgrammed = 8'h60;
    logic signed [7:0] zoneLowLimit = 8'h10, zoneHighLimit = 8'h40;
    logic signed [7:0] peciZeroTemp, peciOneTemp, opPoint, tminActive;
    logic opPointCaptured, dynamicActive;
    int miscompares = 0, testsRun = 0;

    pdto_block pdto_block_inst (.clk(clk), .srst(srst), .regAddr(regAddr),
        .regWrEn(regWrEn), .regWrData(regWrData), .regRdData(regRdData),
        .configLock(configLock), .monitorTick(monitorTick),
        .overtempInput(overtempInput), .peciZeroValid(peciZeroValid),
        .peciZeroRaw(peciZeroRaw), .peciOneValid(peciOneValid),
        .peciOneRaw(peciOneRaw), .tminProgrammed(tminProgrammed),
        .opPointProgrammed(opPointProgrammed), .zoneLowLimit(zoneLowLimit),
        .zoneHighLimit(zoneHighLimit), .peciZeroTemp(peciZeroTemp),
        .peciOneTemp(peciOneTemp), .opPoint(opPoint),
        .opPointCaptured(opPointCaptured), .tminActive(tminActive),
        .dynamicActive(dynamicActive));

    // one-cycle write strobe, lowered on the following edge
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        regAddr <= a;
        regWrData <= d;
        regWrEn <= 1'b1;
        @(posedge clk);
        regWrEn <= 1'b0;
    endtask
    // read data is registered, so wait two edges after the address moves
    task automatic chk(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        regAddr <= a;
        repeat (2) @(posedge clk);
        #1;
        `CMP(regRdData, e);
    endtask
    // same raw value on both channels, corrected results one edge later
    task automatic meas(input logic [7:0] r, input logic [7:0] e0,
                        input logic [7:0] e1);
        @(posedge clk);
        peciZeroValid <= 1'b1;
        peciOneValid <= 1'b1;
        peciZeroRaw <= r;
        peciOneRaw <= r;
        @(posedge clk);
        peciZeroValid <= 1'b0;
        peciOneValid <= 1'b0;
        #1;
        `CMP(peciZeroTemp, e0);
        `CMP(peciOneTemp, e1);
    endtask
    task automatic tick(input int n);
        repeat (n) begin
            @(posedge clk);
            monitorTick <= 1'b1;
            @(posedge clk);
            monitorTick <= 1'b0;
        end
        repeat (2) @(posedge clk);
        #1;
    endtask
    // pulse counted over four samples so the exact lag does not matter
    task automatic tCap(input logic en);
        logic [3:0] p;
        p = 4'h0;
        wr(CTRL_ADDR, en ? 8'h40 : 8'h00);
        meas(8'h44, 8'h44, 8'h44);
        @(posedge clk);
        overtempInput <= 1'b1;
        @(posedge clk);
        overtempInput <= 1'b0;
        repeat (4) begin
            #1;
            p = p + {3'h0, opPointCaptured};
            @(posedge clk);
        end
        `CMP(p, {3'h0, en});
        `CMP(opPoint, en ? 8'h44 : 8'h60);
        $display("capture test done, enable %0d", en);
    endtask
    // hot reading steps down after 8<<c ticks, cold steps up after 16<<c
    task automatic tDyn(input logic [2:0] c, input logic hot);
        int n;
        n = (hot ? 8 : 16) << c;
        wr(CTRL_ADDR, 8'h00);
        meas(hot ? 8'h50 : 8'h05, hot ? 8'h50 : 8'h05, hot ? 8'h50 : 8'h05);
        tick(8);
        `CMP(tminActive, 8'h30);
        wr(CTRL_ADDR, {2'b10, c, 3'b000});
        tick(n - 1);
        `CMP(dynamicActive, 1'b1);
        `CMP(tminActive, 8'h30);
        tick(1);
        `CMP(tminActive, hot ? 8'h2f : 8'h31);
        $display("dynamic test done, code %0d hot %0d", c, hot);
    endtask
    task automatic conclude;
        $display("compares %0d mismatches %0d", testsRun, miscompares);
        if (miscompares == 0 && testsRun > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    initial begin
        forever #2.5 clk = ~clk;
    end
    // hang guard, several times the expected run length
    initial begin
        #300000;
        miscompares++;
        conclude();
    end
    initial begin
        repeat (12) @(posedge clk);
        srst <= 1'b0;
        chk(CTRL_ADDR, CTRL_RESET);
        chk(OFF0_ADDR, OFF_RESET);
        chk(OFF1_ADDR, OFF_RESET);
        chk(8'h91, 8'h00);
        $display("reset test done");
        // low bits are reserved and read back as zero
        wr(CTRL_ADDR, 8'hff);
        chk(CTRL_ADDR, 8'hf8);
        wr(OFF0_ADDR, 8'h80);
        chk(OFF0_ADDR, 8'hc1);
        wr(OFF1_ADDR, 8'h7f);
        chk(OFF1_ADDR, 8'h7f);
        // both range ends, saturating on each side
        meas(8'h70, 8'h31, 8'h7f);
        meas(8'h90, 8'h80, 8'h0f);
        $display("offset test done");
        @(posedge clk);
        configLock <= 1'b1;
        wr(OFF0_ADDR, 8'h00);
        wr(OFF1_ADDR, 8'h00);
        wr(CTRL_ADDR, 8'h00);
        chk(OFF0_ADDR, 8'hc1);
        chk(OFF1_ADDR, 8'h7f);
        chk(CTRL_ADDR, 8'hf8);
        @(posedge clk);
        configLock <= 1'b0;
        wr(OFF0_ADDR, 8'h00);
        wr(OFF1_ADDR, 8'h00);
        $display("lock test done");
        tCap(1'b1);
        tCap(1'b0);
        for (int c = 0; c < 8; c++) begin
            tDyn(c[2:0], 1'b1);
            tDyn(c[2:0], 1'b0);
        end
        conclude();
    end
endmodule
